// ---- design/hrm_ctrl.sv ----
`timescale 1ns/1ps

// ----------------------------------------------------------------------------
// Synchronous FIFO with registered flags
// ----------------------------------------------------------------------------
module hrm_fifo
    import hrm_pkg::*;
#(
    parameter int unsigned WIDTH = FIFO_WIDTH,
    parameter int unsigned DEPTH = FIFO_DEPTH
)(
    input  wire logic             mclk_i,
    input  wire logic             srst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    // Storage and pointers
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic [AW:0]      count_next;
    logic             push;
    logic             pop;

    assign push       = in_valid_i && in_ready_o;
    assign pop        = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_reg];

    // Occupancy after this cycle
    always_comb
    begin
        count_next = count_reg;
        if (push && !pop)
            count_next = count_reg + 1'b1;
        else if (pop && !push)
            count_next = count_reg - 1'b1;
    end

    // Pointers, count and flags
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            wr_ptr_reg  <= '0;
            rd_ptr_reg  <= '0;
            count_reg   <= '0;
            in_ready_o  <= 1'b1;
            out_valid_o <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            count_reg   <= count_next;
            in_ready_o  <= (count_next != (AW+1)'(DEPTH));
            out_valid_o <= (count_next != '0);
        end
    end

    // Data array has no reset
    always_ff @(posedge mclk_i)
    begin
        if (push)
            mem[wr_ptr_reg] <= in_data_i;
    end

endmodule : hrm_fifo

// ----------------------------------------------------------------------------
// High-rate mode control top
// ----------------------------------------------------------------------------
module hrm_ctrl
    import hrm_pkg::*;
#(
    parameter int unsigned ED_STD_CYCLES    = ED_STD_CYC,
    parameter int unsigned ED_SHORT_CYCLES  = ED_SHORT_CYC,
    parameter int unsigned ACK_STD_CYCLES   = ACK_STD_CYC,
    parameter int unsigned ACK_SHORT_CYCLES = ACK_SHORT_CYC
)(
    input  wire logic        mclk_i,
    input  wire logic        srst_i,
    // Register port
    input  wire logic [5:0]  reg_addr_i,
    input  wire logic [7:0]  reg_wdata_i,
    input  wire logic        reg_we_i,
    input  wire logic        reg_re_i,
    output logic      [7:0]  reg_rdata_o,
    // Frame events from the modem
    input  wire logic        shr_found_i,
    input  wire logic        tx_start_i,
    input  wire logic        phr_done_i,
    input  wire logic        frame_end_i,
    input  wire logic        payload_fail_i,
    input  wire logic [4:0]  rssi_i,
    input  wire logic        auto_ack_receive_state_i,
    input  wire logic        ack_request_i,
    input  wire logic        ed_start_i,
    input  wire logic [7:0]  energy_detect_result_i,
    input  wire logic [7:0]  link_quality_value_i,
    // Modem control
    output logic      [1:0]  modem_rate_o,
    output logic             ed_active_o,
    output logic             ack_start_o,
    output logic             frame_ignore_o,
    output logic             frame_reject_o,
    // Received payload stream in
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        rx_byte_valid_i,
    output logic             rx_byte_ready_o,
    // Frame buffer stream out
    output logic      [7:0]  fb_data_o,
    output logic             fb_valid_o,
    input  wire logic        fb_ready_i
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        hrm_rate_t  psdu_rate_select;     // Software rate code
        logic       safe_mode;            // Stored only
        logic       short_ack_delay;      // Short acknowledge turnaround
        logic       reserved_frame_filter;
        logic       reserved_frame_upload;
        logic       promiscuous_receive;
        logic [3:0] rx_sensitivity_threshold;
        hrm_phase_t phase;                // Frame phase
        logic       frame_rx;             // Current frame is a reception
        hrm_rate_t  frame_rate;           // Rate latched for this frame
        hrm_rate_t  modem_rate;           // Rate applied to the modem
        logic [15:0] ed_cnt;              // Energy window countdown
        logic       ed_active;
        logic [15:0] ack_cnt;             // Acknowledge turnaround countdown
        logic       ack_wait;
        logic       ack_start;
        logic       ignore;
        logic       reject;
        logic       trail_pend;           // Trailer byte waits for buffer
        logic [7:0] trail_byte;
        logic [7:0] rdata;
    } hrm_state_t;

    hrm_state_t st_reg;
    hrm_state_t st_next;

    // Buffer signals
    logic [7:0] fifo_in_data;
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic       payload_take;
    logic       trail_take;

    // Payload bytes only pass while a received payload is open
    assign payload_take  = rx_byte_valid_i && st_reg.frame_rx && (st_reg.phase == PH_PAY);
    // Trailer enters only when no payload byte competes
    assign trail_take    = st_reg.trail_pend && !payload_take && fifo_in_ready;
    assign fifo_in_valid = payload_take || st_reg.trail_pend;
    assign fifo_in_data  = payload_take ? rx_byte_i : st_reg.trail_byte;

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb
    begin
        st_next           = st_reg;
        st_next.ack_start = 1'b0;
        st_next.ignore    = 1'b0;
        st_next.reject    = 1'b0;

        // Register writes
        if (reg_we_i)
        begin
            unique case (reg_addr_i)
                ADDR_TRX_CTRL_TWO:
                begin
                    st_next.psdu_rate_select = hrm_rate_t'(reg_wdata_i[RATE_LSB +: 2]);
                    st_next.safe_mode        = reg_wdata_i[SAFE_BIT];
                end
                ADDR_AACK_CTRL:
                begin
                    st_next.short_ack_delay       = reg_wdata_i[SACK_BIT];
                    st_next.reserved_frame_filter = reg_wdata_i[FLTR_BIT];
                    st_next.reserved_frame_upload = reg_wdata_i[UPLD_BIT];
                    st_next.promiscuous_receive   = reg_wdata_i[PROM_BIT];
                end
                ADDR_RX_SYNC:
                    st_next.rx_sensitivity_threshold = reg_wdata_i[PDT_LSB +: 4];
                default:
                begin
                    // Unmapped writes are ignored
                end
            endcase
        end

        // Register reads; unmapped and reserved bits read zero
        if (reg_re_i)
        begin
            st_next.rdata = 8'h00;
            if (reg_addr_i == ADDR_TRX_CTRL_TWO)
            begin
                st_next.rdata[RATE_LSB +: 2] = st_reg.psdu_rate_select;
                st_next.rdata[SAFE_BIT]      = st_reg.safe_mode;
            end
            else if (reg_addr_i == ADDR_AACK_CTRL)
            begin
                st_next.rdata[SACK_BIT] = st_reg.short_ack_delay;
                st_next.rdata[FLTR_BIT] = st_reg.reserved_frame_filter;
                st_next.rdata[UPLD_BIT] = st_reg.reserved_frame_upload;
                st_next.rdata[PROM_BIT] = st_reg.promiscuous_receive;
            end
            else if (reg_addr_i == ADDR_RX_SYNC)
                st_next.rdata[PDT_LSB +: 4] = st_reg.rx_sensitivity_threshold;
        end

        // Frame phase; the trailer byte and the energy window also look at the frame rate
        unique case (st_reg.phase)
            PH_IDLE:
            begin
                st_next.modem_rate = RATE_250K;
                if (shr_found_i)
                begin
                    if ((st_reg.rx_sensitivity_threshold != 4'h0)
                        && ({1'b0, st_reg.rx_sensitivity_threshold} > rssi_i))
                        st_next.ignore = 1'b1;
                    else
                    begin
                        st_next.phase      = PH_HDR;
                        st_next.frame_rx   = 1'b1;
                        st_next.frame_rate = st_reg.psdu_rate_select;
                    end
                end
                else if (tx_start_i)
                begin
                    st_next.phase      = PH_HDR;
                    st_next.frame_rx   = 1'b0;
                    st_next.frame_rate = st_reg.psdu_rate_select;
                end
            end
            PH_HDR:
            begin
                // Header octets stay at the base rate
                if (phr_done_i)
                begin
                    st_next.phase      = PH_PAY;
                    st_next.modem_rate = st_reg.frame_rate;
                end
            end
            PH_PAY:
            begin
                if (payload_fail_i && st_reg.frame_rx)
                begin
                    st_next.phase      = PH_IDLE;
                    st_next.modem_rate = RATE_250K;
                    st_next.reject     = 1'b1;
                end
                else if (frame_end_i)
                begin
                    st_next.phase      = PH_IDLE;
                    st_next.modem_rate = RATE_250K;
                    if (st_reg.frame_rx)
                    begin
                        st_next.trail_pend = 1'b1;
                        st_next.trail_byte = (st_reg.frame_rate != RATE_250K)
                                           ? energy_detect_result_i
                                           : link_quality_value_i;
                        if (auto_ack_receive_state_i && ack_request_i)
                        begin
                            st_next.ack_wait = 1'b1;
                            st_next.ack_cnt  = st_reg.short_ack_delay
                                ? 16'(ACK_SHORT_CYCLES - 1)
                                : 16'(ACK_STD_CYCLES - 1);
                        end
                    end
                end
            end
            default:
            begin
                st_next.phase      = PH_IDLE;
                st_next.modem_rate = RATE_250K;
            end
        endcase

        // Trailer leaves once the buffer takes it
        if (trail_take)
            st_next.trail_pend = 1'b0;

        // Acknowledge turnaround countdown
        if (st_reg.ack_wait)
        begin
            if (st_reg.ack_cnt == 16'h0000)
            begin
                st_next.ack_wait  = 1'b0;
                st_next.ack_start = 1'b1;
            end
            else
                st_next.ack_cnt = st_reg.ack_cnt - 16'h0001;
        end

        // Energy window, shorter for high-rate frames
        if (ed_start_i)
        begin
            st_next.ed_active = 1'b1;
            st_next.ed_cnt    = (st_reg.frame_rate != RATE_250K)
                              ? 16'(ED_SHORT_CYCLES - 1)
                              : 16'(ED_STD_CYCLES - 1);
        end
        else if (st_reg.ed_active)
        begin
            if (st_reg.ed_cnt == 16'h0000)
                st_next.ed_active = 1'b0;
            else
                st_next.ed_cnt = st_reg.ed_cnt - 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            st_reg                          <= '0;
            st_reg.psdu_rate_select         <= hrm_rate_t'(RATE_RESET);
            st_reg.rx_sensitivity_threshold <= PDT_RESET;
            st_reg.phase                    <= PH_IDLE;
        end
        else
            st_reg <= st_next;
    end

    // ------------------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------------------
    hrm_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk_i      (mclk_i),
        .srst_i      (srst_i),
        .in_data_i   (fifo_in_data),
        .in_valid_i  (fifo_in_valid),
        .in_ready_o  (fifo_in_ready),
        .out_data_o  (fb_data_o),
        .out_valid_o (fb_valid_o),
        .out_ready_i (fb_ready_i)
    );

    // Outputs straight from state flops
    assign rx_byte_ready_o = fifo_in_ready;
    assign reg_rdata_o     = st_reg.rdata;
    assign modem_rate_o    = st_reg.modem_rate;
    assign ed_active_o     = st_reg.ed_active;
    assign ack_start_o     = st_reg.ack_start;
    assign frame_ignore_o  = st_reg.ignore;
    assign frame_reject_o  = st_reg.reject;

endmodule : hrm_ctrl

// ---- design/hrm_pkg.sv ----
// ----------------------------------------------------------------------------
// Shared constants for the high-rate PHY mode control
// ----------------------------------------------------------------------------
package hrm_pkg;

    // Clock rate in kHz (250 MHz)
    localparam int unsigned CLK_KHZ = 250000;

    // Register addresses on the register port
    localparam logic [5:0] ADDR_TRX_CTRL_TWO = 6'h0C;
    localparam logic [5:0] ADDR_RX_SYNC      = 6'h15;
    localparam logic [5:0] ADDR_AACK_CTRL    = 6'h17;

    // Field positions in transceiver_control_two
    localparam int RATE_LSB  = 0;
    localparam int SAFE_BIT  = 7;
    // Field positions in auto_ack_control_one
    localparam int PROM_BIT  = 1;
    localparam int SACK_BIT  = 2;
    localparam int UPLD_BIT  = 4;
    localparam int FLTR_BIT  = 5;
    // Field position of the sensitivity threshold in the sync register
    localparam int PDT_LSB   = 0;

    // Values after reset
    localparam logic [1:0] RATE_RESET = 2'h0;
    localparam logic [3:0] PDT_RESET  = 4'h0;

    // Times in ns as printed
    localparam int unsigned SYMBOL_NS    = 16000;
    localparam int unsigned ED_SYMBOLS   = 8;
    localparam int unsigned ACK_SYMBOLS  = 12;
    localparam int unsigned ED_SHORT_NS  = 32000;
    localparam int unsigned ACK_SHORT_NS = 32000;

    // Cycle counts derived from the times (exact at this rate)
    localparam int unsigned ED_STD_CYC    = ED_SYMBOLS * SYMBOL_NS / 1000 * CLK_KHZ / 1000;
    localparam int unsigned ED_SHORT_CYC  = ED_SHORT_NS / 1000 * CLK_KHZ / 1000;
    localparam int unsigned ACK_STD_CYC   = ACK_SYMBOLS * SYMBOL_NS / 1000 * CLK_KHZ / 1000;
    localparam int unsigned ACK_SHORT_CYC = ACK_SHORT_NS / 1000 * CLK_KHZ / 1000;

    // Receive data buffer shape
    localparam int unsigned FIFO_WIDTH = 8;
    localparam int unsigned FIFO_DEPTH = 32;

    // Payload rate codes
    typedef enum logic [1:0] {
        RATE_250K = 2'h0,
        RATE_500K = 2'h1,
        RATE_1M   = 2'h2,
        RATE_2M   = 2'h3
    } hrm_rate_t;

    // Frame phase, Gray coded along idle -> header -> payload
    typedef enum logic [1:0] {
        PH_IDLE = 2'h0,
        PH_HDR  = 2'h1,
        PH_PAY  = 2'h3
    } hrm_phase_t;

endpackage : hrm_pkg

// ---- test/hrm_ctrl_monitor.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Port checker for the high-rate mode control
// ----------------------------------------------------------------------------
module hrm_ctrl_monitor
    import hrm_pkg::*;
(
    input wire logic       mclk_i,
    input wire logic       srst_i,
    input wire logic       shr_found_i,
    input wire logic       phr_done_i,
    input wire logic       frame_end_i,
    input wire logic       auto_ack_receive_state_i,
    input wire logic       ack_request_i,
    input wire logic       ed_start_i,
    input wire logic [1:0] modem_rate_o,
    input wire logic       ed_active_o,
    input wire logic       ack_start_o,
    input wire logic       frame_ignore_o,
    input wire logic       frame_reject_o,
    input wire logic [7:0] fb_data_o,
    input wire logic       fb_valid_o,
    input wire logic       fb_ready_i
);
    default clocking mon_cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    // Frame end that owes an acknowledgment
    sequence ack_cause_s;
        frame_end_i && auto_ack_receive_state_i && ack_request_i;
    endsequence

    // No acknowledgment in the first cycles, even with the short turnaround
    sequence ack_quiet_s;
        !ack_start_o [*8];
    endsequence

    ack_pulse_a: assert property (ack_start_o |=> !ack_start_o)
        else $error("ack start longer than one cycle");
    ack_early_a: assert property (ack_cause_s |-> ack_quiet_s)
        else $error("ack start too early");
    ignore_pulse_a: assert property (frame_ignore_o |=> !frame_ignore_o)
        else $error("ignore pulse longer than one cycle");
    reject_pulse_a: assert property (frame_reject_o |=> !frame_reject_o)
        else $error("reject pulse longer than one cycle");
    end_base_rate_a: assert property (frame_end_i |=> modem_rate_o == 2'h0)
        else $error("rate not back to base after frame");
    rate_cause_a: assert property (($changed(modem_rate_o) && modem_rate_o != 2'h0)
        |-> $past(phr_done_i)) else $error("rate switched without header end");
    header_rate_a: assert property ((shr_found_i && modem_rate_o == 2'h0 && !phr_done_i)
        |=> modem_rate_o == 2'h0) else $error("header not at base rate");
    ed_window_a: assert property (ed_start_i |=> ed_active_o [*8])
        else $error("energy window shorter than minimum");
    fb_hold_a: assert property ((fb_valid_o && !fb_ready_i)
        |=> (fb_valid_o && $stable(fb_data_o))) else $error("buffer byte dropped");
endmodule : hrm_ctrl_monitor

bind hrm_ctrl hrm_ctrl_monitor mon_u (
    .mclk_i(mclk_i), .srst_i(srst_i), .shr_found_i(shr_found_i),
    .phr_done_i(phr_done_i), .frame_end_i(frame_end_i),
    .auto_ack_receive_state_i(auto_ack_receive_state_i), .ack_request_i(ack_request_i),
    .ed_start_i(ed_start_i), .modem_rate_o(modem_rate_o), .ed_active_o(ed_active_o),
    .ack_start_o(ack_start_o), .frame_ignore_o(frame_ignore_o),
    .frame_reject_o(frame_reject_o), .fb_data_o(fb_data_o), .fb_valid_o(fb_valid_o),
    .fb_ready_i(fb_ready_i));

// ---- test/hrm_host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Host reading the frame buffer stream
// ----------------------------------------------------------------------------
module hrm_host_model
    import hrm_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       srst_i,
    input  wire logic       stall_i,
    input  wire logic [7:0] fb_data_i,
    input  wire logic       fb_valid_i,
    output logic            fb_ready_o
);
    logic [7:0] got [0:63];  // Bytes taken from the buffer
    int         got_cnt;     // Count of bytes taken

    // Ready drops while the host is busy elsewhere
    assign fb_ready_o = !stall_i;

    // Keep the first 64 accepted bytes in arrival order
    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
            got_cnt <= 0;
        else if (fb_valid_i && fb_ready_o && got_cnt < 64)
        begin
            got[got_cnt] <= fb_data_i;
            got_cnt      <= got_cnt + 1;
        end
    end
endmodule : hrm_host_model

// ---- test/test_high_rate_phy_mode_control.sv ----
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Bench for the high-rate mode control
// ----------------------------------------------------------------------------
module test_high_rate_phy_mode_control;
    import hrm_pkg::*;
    logic       mclk_i;
    logic       srst_i          = 1'b1;
    logic [5:0] reg_addr_i      = 6'h00;
    logic [7:0] reg_wdata_i     = 8'h00;
    logic       reg_we_i        = 1'b0;
    logic       reg_re_i        = 1'b0;
    logic [4:0] ev              = 5'h00;  // Pulses: shr, phr, end, fail, energy
    logic [4:0] rssi_i          = 5'h10;
    logic [7:0] rx_byte_i       = 8'h00;
    logic       rx_byte_valid_i = 1'b0;
    logic       stall           = 1'b0;   // Host busy
    logic       aack_state      = 1'b1;   // Auto-ack receive state level
    logic       ack_req         = 1'b1;   // Frame asks for acknowledgment
    logic [7:0] ed_val          = 8'hE5;  // Energy result offered by the modem
    logic [7:0] lqi_val         = 8'h1A;  // Link quality offered by the modem
    logic [1:0] modem_rate_o;
    logic [7:0] reg_rdata_o, fb_data_o;
    logic       ed_active_o, ack_start_o, frame_ignore_o, frame_reject_o;
    logic       rx_byte_ready_o, fb_valid_o, fb_ready_i;
    int         errors          = 0;
    int         compares        = 0;

    // Short counts keep the run brief
    hrm_ctrl #(.ED_STD_CYCLES(20), .ED_SHORT_CYCLES(8), .ACK_STD_CYCLES(24),
        .ACK_SHORT_CYCLES(8)) dut_u (
        .mclk_i(mclk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
        .reg_rdata_o(reg_rdata_o), .shr_found_i(ev[0]), .tx_start_i(1'b0),
        .phr_done_i(ev[1]), .frame_end_i(ev[2]), .payload_fail_i(ev[3]),
        .rssi_i(rssi_i), .auto_ack_receive_state_i(aack_state), .ack_request_i(ack_req),
        .ed_start_i(ev[4]), .energy_detect_result_i(ed_val),
        .link_quality_value_i(lqi_val), .modem_rate_o(modem_rate_o),
        .ed_active_o(ed_active_o), .ack_start_o(ack_start_o),
        .frame_ignore_o(frame_ignore_o), .frame_reject_o(frame_reject_o),
        .rx_byte_i(rx_byte_i), .rx_byte_valid_i(rx_byte_valid_i),
        .rx_byte_ready_o(rx_byte_ready_o), .fb_data_o(fb_data_o),
        .fb_valid_o(fb_valid_o), .fb_ready_i(fb_ready_i));

    hrm_host_model host_u (.mclk_i(mclk_i), .srst_i(srst_i), .stall_i(stall),
        .fb_data_i(fb_data_o), .fb_valid_i(fb_valid_o), .fb_ready_o(fb_ready_i));

    // Free-running clock
    initial
    begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    task automatic end_sim;
        if (errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic timed_out;
        errors++;
        end_sim();
    endtask : timed_out

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_we_i    <= 1'b1;
        @(posedge mclk_i);
        reg_we_i    <= 1'b0;
    endtask : wr

    // Read data shows one cycle after the taking edge
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_re_i   <= 1'b1;
        @(posedge mclk_i);
        reg_re_i   <= 1'b0;
        @(posedge mclk_i);
        chk(reg_rdata_o, exp);
    endtask : rd_chk

    // One-cycle event, taken at the closing edge
    task automatic pulse(input int b);
        @(posedge mclk_i);
        ev[b] <= 1'b1;
        @(posedge mclk_i);
        ev[b] <= 1'b0;
    endtask : pulse

    task automatic push(input logic [7:0] b);
        int w;
        @(posedge mclk_i);
        rx_byte_i       <= b;
        rx_byte_valid_i <= 1'b1;
        w = 0;
        @(posedge mclk_i);
        while (rx_byte_ready_o !== 1'b1 && w < 50)
        begin
            @(posedge mclk_i);
            w++;
        end
        if (w >= 50)
            timed_out();
        rx_byte_valid_i <= 1'b0;
    endtask : push

    // Count the cycles the energy window stays open
    task automatic ed_window(input int exp);
        int k;
        pulse(4);
        k = 0;
        repeat (60)
        begin
            @(posedge mclk_i);
            if (ed_active_o === 1'b1)
                k++;
        end
        chk(8'(k), 8'(exp));
    endtask : ed_window

    task automatic reg_test;
        rd_chk(ADDR_TRX_CTRL_TWO, 8'h00);
        rd_chk(ADDR_AACK_CTRL, 8'h00);
        wr(ADDR_TRX_CTRL_TWO, 8'hFF);
        rd_chk(ADDR_TRX_CTRL_TWO, 8'h83);
        wr(ADDR_AACK_CTRL, 8'hFF);
        rd_chk(ADDR_AACK_CTRL, 8'h36);
        wr(ADDR_RX_SYNC, 8'hFF);
        rd_chk(ADDR_RX_SYNC, 8'h0F);
        wr(6'h3F, 8'hFF);
        rd_chk(6'h3F, 8'h00);
    endtask : reg_test

    // Receive one frame, check rates, turnaround, buffer bytes and energy window
    task automatic frame(input logic [1:0] rate, input logic sack, input int n,
                         input logic hold);
        int base;
        int k;
        wr(ADDR_TRX_CTRL_TWO, {6'h00, rate});
        wr(ADDR_AACK_CTRL, {5'h00, sack, 2'h0});
        wr(ADDR_RX_SYNC, {7'h00, rate == 2'h3});
        stall <= hold;
        base = host_u.got_cnt;
        pulse(0);
        @(posedge mclk_i);
        chk(8'(modem_rate_o), 8'h00);
        pulse(1);
        @(posedge mclk_i);
        chk(8'(modem_rate_o), 8'(rate));
        for (k = 0; k < n; k++)
            push(8'(k + 1));
        repeat (2) @(posedge mclk_i);
        if (hold)
            chk(8'(rx_byte_ready_o), 8'h00);
        pulse(2);
        @(posedge mclk_i);
        chk(8'(modem_rate_o), 8'h00);
        k = 1;
        while (ack_start_o !== 1'b1 && k < 100)
        begin
            @(posedge mclk_i);
            k++;
        end
        chk(8'(k), sack ? 8'h09 : 8'h19);
        stall <= 1'b0;
        k = 0;
        while (host_u.got_cnt < base + n + 1 && k < 200)
        begin
            @(posedge mclk_i);
            k++;
        end
        if (k >= 200)
            timed_out();
        for (k = 0; k < n; k++)
            chk(host_u.got[base + k], 8'(k + 1));
        chk(host_u.got[base + n], (rate != 2'h0) ? 8'hE5 : 8'h1A);
        ed_window((rate != 2'h0) ? 8 : 20);
    endtask : frame

    // Threshold drop, then a failed payload rejected at default threshold
    task automatic gate_test;
        wr(ADDR_TRX_CTRL_TWO, 8'h03);
        wr(ADDR_RX_SYNC, 8'h04);
        rssi_i <= 5'h03;
        pulse(0);
        @(posedge mclk_i);
        chk(8'(frame_ignore_o), 8'h01);
        pulse(1);
        @(posedge mclk_i);
        chk(8'(modem_rate_o), 8'h00);
        rssi_i <= 5'h04;
        pulse(0);
        @(posedge mclk_i);
        chk(8'(frame_ignore_o), 8'h00);
        wr(ADDR_RX_SYNC, 8'h00);
        pulse(1);
        @(posedge mclk_i);
        chk(8'(modem_rate_o), 8'h03);
        pulse(3);
        @(posedge mclk_i);
        chk(8'(frame_reject_o), 8'h01);
    endtask : gate_test

    // Main sequence
    initial
    begin
        repeat (3) @(posedge mclk_i);
        srst_i <= 1'b0;
        reg_test();
        frame(2'h0, 1'b0, 3, 1'b0);
        frame(2'h1, 1'b1, 3, 1'b0);
        frame(2'h2, 1'b0, 3, 1'b0);
        frame(2'h3, 1'b1, 3, 1'b0);
        frame(2'h0, 1'b0, 32, 1'b1);
        gate_test();
        end_sim();
    end
endmodule : test_high_rate_phy_mode_control
